//--- rtl/asd_pkg.sv
// shared constants and carriers for the setup and diagnostic register bank
package asd_pkg;

   // register addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h01;
   localparam logic [7:0] ADDR_FAULT   = 8'h06;
   localparam logic [7:0] ADDR_FLT_EN  = 8'h07;
   localparam logic [7:0] ADDR_TALLY   = 8'h08;
   localparam logic [7:0] ADDR_CFG0    = 8'h19;
   localparam logic [7:0] ADDR_DECIM0  = 8'h28;
   localparam logic [7:0] ADDR_ZERO0   = 8'h29;
   localparam logic [7:0] ADDR_SPAN0   = 8'h31;

   // values after reset
   localparam logic [15:0] CONTROL_RST = 16'h0000;
   localparam logic [23:0] FAULT_RST   = 24'h000000;
   localparam logic [23:0] FLT_EN_RST  = 24'h000040;
   localparam logic [7:0]  TALLY_RST   = 8'h00;
   localparam logic [15:0] CFG0_RST    = 16'h0860;
   localparam logic [23:0] DECIM0_RST  = 24'h060180;
   localparam logic [23:0] ZERO0_RST   = 24'h800000;
   localparam logic [23:0] SPAN0_DFLT  = 24'h500000;

   // writable bits, and the valid fault flag bits; the rest read as zero
   localparam logic [15:0] CONTROL_WMASK = 16'h1FFF;
   localparam logic [15:0] CFG0_WMASK    = 16'h0FFF;
   localparam logic [23:0] DECIM0_WMASK  = 24'hFF07FF;
   localparam logic [23:0] FLT_EN_WMASK  = 24'h7FFFFF;
   localparam logic [23:0] FAULT_VALID   = 24'h0FFAFF;

   // fault flag positions
   localparam int FLT_ROM_CHK   = 0;
   localparam int FLT_MAP_CHK   = 1;
   localparam int FLT_SER_CHK   = 2;
   localparam int FLT_WRITE     = 3;
   localparam int FLT_READ      = 4;
   localparam int FLT_SCLK      = 5;
   localparam int FLT_IGNORE    = 6;
   localparam int FLT_LDO_CAP   = 19;
   // enable positions that differ from the flag layout
   localparam int EN_LDO_CAP_LO = 19;
   localparam int EN_LDO_CAP_HI = 20;
   localparam int EN_TALLY      = 22;

   // control field positions
   localparam int CTL_CLK_SEL_LO = 0;
   localparam int CTL_MODE_LO    = 2;
   localparam int CTL_POWER_LO   = 6;
   localparam int CTL_REF_EN     = 8;
   localparam int CTL_CS_EN      = 9;
   localparam int CTL_STATUS_APP = 10;
   localparam int CTL_REPEAT_RD  = 11;
   localparam int CTL_RDY_DELAY  = 12;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [23:0] wdata;
   } asd_req_t;

   typedef struct packed {
      logic        zero_vld;
      logic        span_vld;
      logic [23:0] value;
   } asd_cal_t;

   // msb first, so the struct lines up with control word bits 12:0
   typedef struct packed {
      logic       ready_output_delay;
      logic       repeat_read_mode;
      logic       status_append;
      logic       cs_enable;
      logic       ref_enable;
      logic [1:0] power_level;
      logic [3:0] op_mode;
      logic [1:0] clock_select;
   } asd_ctrl_t;

endpackage : asd_pkg

//--- rtl/asd_register_bank.sv
// setup, diagnostic and control register bank of the converter
`timescale 1ns/1ps
`default_nettype none

// Operation
// - zero correction register is 24-bit read/write, resets to mid-scale.
// - zero correction takes calibration result or host written value.
// - span correction is 24-bit read/write, resets to per-unit trimmed value.
// - span correction is overwritten by each full-scale calibration result.
// - after reset only the forbidden-time access check is enabled.
// - detected faults set flags only while enabled; summary bit is OR of enabled flags.
// - fault register is 24-bit read-only, resets zero, one flag per source.
// - 8-bit read-only master clock pulse tally resets to zero.
// - enabled read and write checks flag accesses to invalid addresses.
// - enabled serial clock check flags transactions with wrong clock count.
// - control register selects power level and operating mode.
// - control register holds clock select, reference enable, status append, repeat read.
// - setup configuration is 16-bit, resets 0x0860, with documented fields.
// - decimation register is 24-bit, resets 0x060180, with documented fields.
// - control register is 16-bit, resets zero, with documented fields.
module asd_register_bank #(
   parameter logic [23:0] SPAN_TRIM = asd_pkg::SPAN0_DFLT
) (
   // clock, reset, enable
   input  wire logic              mclk,
   input  wire logic              arst_n,
   input  wire logic              clk_en,
   // decoded host access
   input  wire asd_pkg::asd_req_t req_i,
   input  wire logic              host_window_closed,
   input  wire logic              sclk_count_bad,
   // calibration results and monitor faults
   input  wire asd_pkg::asd_cal_t cal_i,
   input  wire logic [23:0]       fault_evt,
   // read answer
   output logic [23:0]            rdata_q,
   output logic                   rvalid_q,
   // status and setup outputs
   output logic                   status_err_q,
   output asd_pkg::asd_ctrl_t     ctrl_q,
   output logic [15:0]            cfg0_q,
   output logic [23:0]            decim0_q,
   output logic [23:0]            zero0_q,
   output logic [23:0]            span0_q,
   output logic [23:0]            fault_q,
   output logic [23:0]            flt_en_q,
   output logic [7:0]             tally_q
);

   logic        rst_s1_q;
   logic        rst_n;
   logic        acc;
   logic        acc_ok;
   logic        addr_ok;
   logic        wr_ok;
   logic        rd_ok;
   logic [15:0] ctrl_raw;
   logic [23:0] flt_set;
   logic [23:0] flt_clr;

   // reset release through two flops
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   function automatic logic known_addr(input logic [7:0] a);
      if (a == asd_pkg::ADDR_CONTROL) known_addr = 1'b1;
      else if (a == asd_pkg::ADDR_FAULT) known_addr = 1'b1;
      else if (a == asd_pkg::ADDR_FLT_EN) known_addr = 1'b1;
      else if (a == asd_pkg::ADDR_TALLY) known_addr = 1'b1;
      else if (a == asd_pkg::ADDR_CFG0) known_addr = 1'b1;
      else if (a == asd_pkg::ADDR_DECIM0) known_addr = 1'b1;
      else if (a == asd_pkg::ADDR_ZERO0) known_addr = 1'b1;
      else if (a == asd_pkg::ADDR_SPAN0) known_addr = 1'b1;
      else known_addr = 1'b0;
   endfunction : known_addr

   // enable layout differs from flag layout near the regulator check
   function automatic logic [23:0] flag_mask(input logic [23:0] en);
      logic [23:0] m;
      m = en & asd_pkg::FAULT_VALID;
      m[asd_pkg::FLT_LDO_CAP] = en[asd_pkg::EN_LDO_CAP_LO] | en[asd_pkg::EN_LDO_CAP_HI];
      flag_mask = m;
   endfunction : flag_mask

   assign acc     = req_i.wr | req_i.rd;
   assign addr_ok = known_addr(req_i.addr);
   // accesses while the window is closed are dropped entirely
   assign acc_ok  = acc & ~host_window_closed;
   assign wr_ok   = acc_ok & req_i.wr & addr_ok;
   assign rd_ok   = acc_ok & req_i.rd & ~req_i.wr & addr_ok;

   always_comb begin
      ctrl_raw = {3'b000, ctrl_q};
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= 13'(asd_pkg::CONTROL_RST);
      end else if (clk_en && wr_ok && req_i.addr == asd_pkg::ADDR_CONTROL) begin
         ctrl_q <= 13'(req_i.wdata[15:0] & asd_pkg::CONTROL_WMASK);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg0_q <= asd_pkg::CFG0_RST;
      end else if (clk_en && wr_ok && req_i.addr == asd_pkg::ADDR_CFG0) begin
         cfg0_q <= req_i.wdata[15:0] & asd_pkg::CFG0_WMASK;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         decim0_q <= asd_pkg::DECIM0_RST;
      end else if (clk_en && wr_ok && req_i.addr == asd_pkg::ADDR_DECIM0) begin
         decim0_q <= req_i.wdata & asd_pkg::DECIM0_WMASK;
      end
   end

   // calibration result beats a same-cycle host write
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         zero0_q <= asd_pkg::ZERO0_RST;
      end else if (clk_en) begin
         if (cal_i.zero_vld) begin
            zero0_q <= cal_i.value;
         end else if (wr_ok && req_i.addr == asd_pkg::ADDR_ZERO0) begin
            zero0_q <= req_i.wdata;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         span0_q <= SPAN_TRIM;
      end else if (clk_en) begin
         if (cal_i.span_vld) begin
            span0_q <= cal_i.value;
         end else if (wr_ok && req_i.addr == asd_pkg::ADDR_SPAN0) begin
            span0_q <= req_i.wdata;
         end
      end
   end

   // only forbidden-time check on at reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flt_en_q <= asd_pkg::FLT_EN_RST;
      end else if (clk_en && wr_ok && req_i.addr == asd_pkg::ADDR_FLT_EN) begin
         flt_en_q <= req_i.wdata & asd_pkg::FLT_EN_WMASK;
      end
   end

   always_comb begin
      flt_set = fault_evt;
      flt_set[asd_pkg::FLT_WRITE]  = fault_evt[asd_pkg::FLT_WRITE]
                                     | (acc_ok & req_i.wr & ~addr_ok);
      flt_set[asd_pkg::FLT_READ]   = fault_evt[asd_pkg::FLT_READ]
                                     | (acc_ok & req_i.rd & ~req_i.wr & ~addr_ok);
      flt_set[asd_pkg::FLT_SCLK]   = fault_evt[asd_pkg::FLT_SCLK] | sclk_count_bad;
      flt_set[asd_pkg::FLT_IGNORE] = fault_evt[asd_pkg::FLT_IGNORE]
                                     | (acc & host_window_closed);
      flt_set = flt_set & flag_mask(flt_en_q);
      // read of the fault register clears what it returned
      flt_clr = (rd_ok && req_i.addr == asd_pkg::ADDR_FAULT) ? fault_q : 24'h000000;
   end

   // enabled faults set their flags, set wins over clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fault_q <= asd_pkg::FAULT_RST;
      end else if (clk_en) begin
         fault_q <= (fault_q & ~flt_clr) | flt_set;
      end
   end

   // summary bit, one cycle behind the flags
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_err_q <= 1'b0;
      end else if (clk_en) begin
         status_err_q <= |(fault_q & flag_mask(flt_en_q));
      end
   end

   // pulse tally, runs only while its check is enabled, wraps
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tally_q <= asd_pkg::TALLY_RST;
      end else if (clk_en && flt_en_q[asd_pkg::EN_TALLY]) begin
         tally_q <= tally_q + 8'h01;
      end
   end

   // read answer one cycle after the request
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q  <= 24'h000000;
         rvalid_q <= 1'b0;
      end else if (clk_en) begin
         rvalid_q <= rd_ok;
         if (!rd_ok) begin
            rdata_q <= 24'h000000;
         end else if (req_i.addr == asd_pkg::ADDR_CONTROL) begin
            rdata_q <= {8'h00, ctrl_raw};
         end else if (req_i.addr == asd_pkg::ADDR_FAULT) begin
            rdata_q <= fault_q;
         end else if (req_i.addr == asd_pkg::ADDR_FLT_EN) begin
            rdata_q <= flt_en_q;
         end else if (req_i.addr == asd_pkg::ADDR_TALLY) begin
            rdata_q <= {16'h0000, tally_q};
         end else if (req_i.addr == asd_pkg::ADDR_CFG0) begin
            rdata_q <= {8'h00, cfg0_q};
         end else if (req_i.addr == asd_pkg::ADDR_DECIM0) begin
            rdata_q <= decim0_q;
         end else if (req_i.addr == asd_pkg::ADDR_ZERO0) begin
            rdata_q <= zero0_q;
         end else begin
            rdata_q <= span0_q;
         end
      end
   end

   AST_ZERO_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> zero0_q == asd_pkg::ZERO0_RST)
      else $error("zero correction not mid-scale after reset");

   AST_ZERO_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && !cal_i.zero_vld && wr_ok && req_i.addr == asd_pkg::ADDR_ZERO0
      |=> zero0_q == $past(req_i.wdata))
      else $error("zero correction did not take host value");

   AST_ZERO_CAL: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && cal_i.zero_vld |=> zero0_q == $past(cal_i.value))
      else $error("zero correction did not take calibration result");

   AST_SPAN_CAL: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && cal_i.span_vld |=> span0_q == $past(cal_i.value))
      else $error("span correction did not take calibration result");

   AST_SPAN_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> span0_q == SPAN_TRIM)
      else $error("span correction not trimmed value after reset");

   AST_EN_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> flt_en_q == asd_pkg::FLT_EN_RST)
      else $error("fault enables wrong after reset");

   AST_SUMMARY: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en |=> status_err_q == $past(|(fault_q & flag_mask(flt_en_q))))
      else $error("summary fault bit mismatch");

   AST_FLAG_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && fault_q[asd_pkg::FLT_IGNORE] && !rd_ok
      |=> fault_q[asd_pkg::FLT_IGNORE] && (fault_q & ~asd_pkg::FAULT_VALID) == 24'h000000)
      else $error("fault flag lost or reserved bit set");

   AST_TALLY_STEP: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && flt_en_q[asd_pkg::EN_TALLY] |=> tally_q == $past(tally_q) + 8'h01)
      else $error("pulse tally did not advance");

   AST_BAD_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && acc_ok && req_i.wr && !addr_ok && flt_en_q[asd_pkg::FLT_WRITE]
      |=> fault_q[asd_pkg::FLT_WRITE])
      else $error("invalid write not flagged");

   AST_SCLK_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && sclk_count_bad && flt_en_q[asd_pkg::FLT_SCLK] |=> fault_q[asd_pkg::FLT_SCLK])
      else $error("serial clock count fault not flagged");

   AST_CTRL_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && wr_ok && req_i.addr == asd_pkg::ADDR_CONTROL
      |=> ctrl_q == ($past(req_i.wdata[15:0]) & asd_pkg::CONTROL_WMASK))
      else $error("control register write lost");

   AST_CFG_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> cfg0_q == asd_pkg::CFG0_RST && decim0_q == asd_pkg::DECIM0_RST)
      else $error("setup registers wrong after reset");

   AST_RO_TALLY: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && !flt_en_q[asd_pkg::EN_TALLY] |=> tally_q == $past(tally_q))
      else $error("pulse tally changed while stopped");

   AST_CTRL_FIELDS: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && wr_ok && req_i.addr == asd_pkg::ADDR_CONTROL
      |=> ctrl_q.power_level == $past(req_i.wdata[asd_pkg::CTL_POWER_LO +: 2])
          && ctrl_q.op_mode == $past(req_i.wdata[asd_pkg::CTL_MODE_LO +: 4])
          && ctrl_q.ready_output_delay == $past(req_i.wdata[asd_pkg::CTL_RDY_DELAY]))
      else $error("control fields in wrong place");

   AST_BAD_READ: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && acc_ok && req_i.rd && !req_i.wr && !addr_ok && flt_en_q[asd_pkg::FLT_READ]
      |=> fault_q[asd_pkg::FLT_READ])
      else $error("invalid read not flagged");

   AST_IGNORE_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && acc && host_window_closed && flt_en_q[asd_pkg::FLT_IGNORE]
      |=> fault_q[asd_pkg::FLT_IGNORE])
      else $error("access in closed window not flagged");

   AST_CLOSED_DROP: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && acc && host_window_closed && !cal_i.zero_vld
      |=> zero0_q == $past(zero0_q))
      else $error("access in closed window changed a register");

   AST_SUMMARY_SET: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && fault_q[asd_pkg::FLT_IGNORE] && flt_en_q[asd_pkg::FLT_IGNORE] |=> status_err_q)
      else $error("summary bit missed an enabled flag");

   AST_CFG_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && wr_ok && req_i.addr == asd_pkg::ADDR_CFG0
      |=> cfg0_q == ($past(req_i.wdata[15:0]) & asd_pkg::CFG0_WMASK))
      else $error("setup configuration write lost");

   AST_DECIM_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && wr_ok && req_i.addr == asd_pkg::ADDR_DECIM0
      |=> decim0_q == ($past(req_i.wdata) & asd_pkg::DECIM0_WMASK))
      else $error("decimation write lost");

   AST_FAULT_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && rd_ok && req_i.addr == asd_pkg::ADDR_FAULT && flt_set == 24'h000000
      |=> fault_q == 24'h000000)
      else $error("fault flags not cleared by read");

endmodule : asd_register_bank

`default_nettype wire

//--- tb/asd_host_model.sv
// host side model issuing single register accesses to the bank
`timescale 1ns/1ps
`default_nettype none

module asd_host_model (
   // clock
   input  wire logic         mclk,
   // register access
   output asd_pkg::asd_req_t req,
   input  wire logic [23:0]  rdata_q,
   input  wire logic         rvalid_q
);

   initial req = '0;

   task automatic write(input logic [7:0] a, input logic [23:0] d);
      @(posedge mclk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      // released fields flip so a stale value never passes as live
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : write

   task automatic read(input logic [7:0] a, output logic [23:0] d, output logic ok);
      int n;
      @(posedge mclk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h000000};
      @(posedge mclk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 24'hFFFFFF};
      ok = 1'b0;
      d = 24'h000000;
      // answer stands one cycle, so look at every falling edge
      for (n = 0; n < 3 && !ok; n++) begin
         @(negedge mclk);
         if (rvalid_q === 1'b1) begin
            ok = 1'b1;
            d = rdata_q;
         end
      end
   endtask : read

endmodule : asd_host_model
`default_nettype wire

//--- tb/asd_register_bank_test.sv
// self-checking bench for the setup and diagnostic register bank
`timescale 1ns/1ps
`default_nettype none

module asd_register_bank_test;

   localparam logic [23:0] TRIM = 24'h51C3A7;

   logic              mclk;
   logic              arst_n;
   logic              clk_en;
   logic              host_window_closed;
   logic              sclk_count_bad;
   logic [23:0]       fault_evt;
   asd_pkg::asd_cal_t cal_i;
   asd_pkg::asd_req_t req;
   logic [23:0]       rdata_q;
   logic              rvalid_q;
   logic              status_err_q;
   logic [23:0]       zero0_q;
   logic [23:0]       span0_q;
   logic [23:0]       fault_q;
   logic [7:0]        tally_q;
   asd_pkg::asd_ctrl_t ctrl_q;
   logic [15:0]       cfg0_q;
   logic [23:0]       decim0_q;
   logic [23:0]       flt_en_q;
   logic [23:0]       d;
   logic              ok;
   int                fails;
   int                n_compared;

   asd_register_bank #(.SPAN_TRIM(TRIM)) u_asd_register_bank (
      .mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .req_i(req),
      .host_window_closed(host_window_closed), .sclk_count_bad(sclk_count_bad),
      .cal_i(cal_i), .fault_evt(fault_evt), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
      .status_err_q(status_err_q), .ctrl_q(ctrl_q), .cfg0_q(cfg0_q), .decim0_q(decim0_q),
      .zero0_q(zero0_q), .span0_q(span0_q), .fault_q(fault_q), .flt_en_q(flt_en_q),
      .tally_q(tally_q)
   );

   asd_host_model u_asd_host_model (
      .mclk(mclk), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q)
   );

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] a, input logic [23:0] exp);
      u_asd_host_model.read(a, d, ok);
      chk({23'h0, ok}, 24'h000001);
      chk(d, exp);
   endtask : rd_chk

   task automatic t_reset_values();
      rd_chk(asd_pkg::ADDR_CONTROL, 24'h000000);
      rd_chk(asd_pkg::ADDR_FAULT, 24'h000000);
      rd_chk(asd_pkg::ADDR_FLT_EN, 24'h000040);
      rd_chk(asd_pkg::ADDR_TALLY, 24'h000000);
      rd_chk(asd_pkg::ADDR_CFG0, 24'h000860);
      rd_chk(asd_pkg::ADDR_DECIM0, 24'h060180);
      rd_chk(asd_pkg::ADDR_ZERO0, 24'h800000);
      rd_chk(asd_pkg::ADDR_SPAN0, TRIM);
   endtask : t_reset_values

   task automatic t_write_back();
      logic [7:0]  ra [5];
      logic [23:0] rm [5];
      int          i;
      ra = '{asd_pkg::ADDR_CONTROL, asd_pkg::ADDR_CFG0, asd_pkg::ADDR_DECIM0,
             asd_pkg::ADDR_ZERO0, asd_pkg::ADDR_SPAN0};
      rm = '{24'h001FFF, 24'h000FFF, 24'hFF07FF, 24'hFFFFFF, 24'hFFFFFF};
      for (i = 0; i < 5; i++) begin
         u_asd_host_model.write(ra[i], 24'hFFFFFF);
         rd_chk(ra[i], rm[i]);
         u_asd_host_model.write(ra[i], 24'hA5A5A5);
         rd_chk(ra[i], rm[i] & 24'hA5A5A5);
      end
      // control holds 0x05A5: power 2, mode 9, status append on
      chk({22'h0, ctrl_q.power_level}, 24'h000002);
      chk({20'h0, ctrl_q.op_mode}, 24'h000009);
      chk({23'h0, ctrl_q.status_append}, 24'h000001);
      chk({8'h00, cfg0_q}, 24'h0005A5);
      chk(decim0_q, 24'hA505A5);
      u_asd_host_model.write(asd_pkg::ADDR_CONTROL, 24'h000000);
      u_asd_host_model.write(asd_pkg::ADDR_FAULT, 24'hFFFFFF);
      u_asd_host_model.write(asd_pkg::ADDR_TALLY, 24'hFFFFFF);
      rd_chk(asd_pkg::ADDR_FAULT, 24'h000000);
      rd_chk(asd_pkg::ADDR_TALLY, 24'h000000);
   endtask : t_write_back

   task automatic t_faults();
      @(posedge mclk);
      sclk_count_bad <= 1'b1;
      fault_evt      <= 24'h000001;
      @(posedge mclk);
      sclk_count_bad <= 1'b0;
      fault_evt      <= 24'h000000;
      repeat (3) @(negedge mclk);
      chk(fault_q, 24'h000000);
      chk({23'h0, status_err_q}, 24'h000000);
      u_asd_host_model.write(asd_pkg::ADDR_FLT_EN, 24'h000078);
      @(posedge mclk);
      sclk_count_bad <= 1'b1;
      @(posedge mclk);
      sclk_count_bad <= 1'b0;
      u_asd_host_model.read(8'h02, d, ok);
      chk({23'h0, ok}, 24'h000000);
      u_asd_host_model.write(8'h3F, 24'h123456);
      host_window_closed <= 1'b1;
      u_asd_host_model.write(asd_pkg::ADDR_ZERO0, 24'h111111);
      host_window_closed <= 1'b0;
      repeat (3) @(negedge mclk);
      chk(zero0_q, 24'hA5A5A5);
      chk(fault_q, 24'h000078);
      chk(flt_en_q, 24'h000078);
      chk({23'h0, status_err_q}, 24'h000001);
      // flags stay but the summary only follows enabled ones
      u_asd_host_model.write(asd_pkg::ADDR_FLT_EN, 24'h000000);
      repeat (3) @(negedge mclk);
      chk({23'h0, status_err_q}, 24'h000000);
      rd_chk(asd_pkg::ADDR_FAULT, 24'h000078);
      repeat (3) @(negedge mclk);
      chk(fault_q, 24'h000000);
   endtask : t_faults

   task automatic t_calibration();
      @(posedge mclk);
      cal_i <= '{zero_vld: 1'b1, span_vld: 1'b0, value: 24'hABCDEF};
      @(posedge mclk);
      cal_i <= '{zero_vld: 1'b0, span_vld: 1'b1, value: 24'h13579B};
      @(posedge mclk);
      cal_i <= '{zero_vld: 1'b0, span_vld: 1'b0, value: 24'hFFFFFF};
      rd_chk(asd_pkg::ADDR_ZERO0, 24'hABCDEF);
      rd_chk(asd_pkg::ADDR_SPAN0, 24'h13579B);
      // calibration result outranks a host write in the same cycle
      fork
         u_asd_host_model.write(asd_pkg::ADDR_ZERO0, 24'h222222);
         begin
            @(posedge mclk);
            cal_i <= '{zero_vld: 1'b1, span_vld: 1'b0, value: 24'h0F0F0F};
            @(posedge mclk);
            cal_i <= '{zero_vld: 1'b0, span_vld: 1'b0, value: 24'h000000};
         end
      join
      rd_chk(asd_pkg::ADDR_ZERO0, 24'h0F0F0F);
   endtask : t_calibration

   task automatic t_tally();
      logic [7:0] t0;
      u_asd_host_model.write(asd_pkg::ADDR_FLT_EN, 24'h400000);
      @(negedge mclk);
      t0 = tally_q;
      repeat (10) @(negedge mclk);
      chk({16'h0, tally_q}, {16'h0, t0 + 8'h0A});
      @(posedge mclk);
      clk_en <= 1'b0;
      @(negedge mclk);
      t0 = tally_q;
      repeat (5) @(negedge mclk);
      chk({16'h0, tally_q}, {16'h0, t0});
      @(posedge mclk);
      clk_en <= 1'b1;
      u_asd_host_model.write(asd_pkg::ADDR_FLT_EN, 24'h000040);
   endtask : t_tally

   task automatic t_rereset();
      u_asd_host_model.write(asd_pkg::ADDR_ZERO0, 24'h123456);
      u_asd_host_model.write(asd_pkg::ADDR_SPAN0, 24'h654321);
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset_values();
      chk({23'h0, status_err_q}, 24'h000000);
   endtask : t_rereset

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (50000) @(posedge mclk);
      fails++;
      tally_and_finish();
   end

   initial begin
      fails = 0;
      n_compared = 0;
      arst_n = 1'b0;
      clk_en = 1'b1;
      host_window_closed = 1'b0;
      sclk_count_bad = 1'b0;
      fault_evt = 24'h000000;
      cal_i = '0;
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset_values();
      t_write_back();
      t_faults();
      t_calibration();
      t_tally();
      t_rereset();
      tally_and_finish();
   end

endmodule : asd_register_bank_test
`default_nettype wire
